// ---- rtl/lses_regs.vh ----
`ifndef LSES_REGS_VH
`define LSES_REGS_VH
`define LSES_IDX_INVALID_FLAGS 12'h46E
`define LSES_IDX_UNEXP_FLAGS 12'h46F
`define LSES_IDX_LINK_PAGE 12'h300
`define LSES_IDX_THRESHOLD 12'h301
`define LSES_IDX_CNT_CLEAR 12'h302
`define LSES_FLAGS_RESET 8'h00
`define LSES_THRESHOLD_RESET 8'hFF
`define LSES_LINK_PAGE_RESET 1'h0
`define LSES_LINK_PAGE_BIT 0
`endif

// ---- rtl/lses_lane_counter.v ----
`timescale 1ns/1ns
module lses_lane_counter #(
    parameter CNT_W = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire clear_i,
    input wire err_i,
    input wire [CNT_W-1:0] threshold_i,
    output reg flag_o
);
    reg [CNT_W-1:0] count;
    wire at_max;
    assign at_max = &count;
    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            count <= {CNT_W{1'b0}};
        end else if (err_i && !at_max) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= (count >= threshold_i);
        end
    end
endmodule

// ---- rtl/lses_lane_symbol_error_status.v ----
`timescale 1ns/1ns
`include "lses_regs.vh"
module lses_lane_symbol_error_status #(
    parameter LANES = 8,
    parameter LINKS = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [13:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg err_o,
    input wire [LINKS*LANES-1:0] invalid_symbol_err_i,
    input wire [LINKS*LANES-1:0] unexpected_control_err_i
);
    reg link_page;
    reg [7:0] error_count_threshold;
    reg [LINKS-1:0] cnt_clear;
    wire [LINKS*LANES-1:0] invalid_flags;
    wire [LINKS*LANES-1:0] unexp_flags;
    wire [11:0] idx;
    wire req;
    wire [7:0] page_invalid;
    wire [7:0] page_unexp;
    reg [31:0] next_dat;
    reg next_err;
    genvar g;

    assign idx = adr_i[13:2];
    assign req = cyc_i && stb_i && !ack_o && !err_o;

    generate
        for (g = 0; g < LINKS*LANES; g = g + 1) begin : lane_g
            lses_lane_counter #(.CNT_W(8)) inv_cnt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .clear_i(cnt_clear[g/LANES]),
                .err_i(invalid_symbol_err_i[g]),
                .threshold_i(error_count_threshold),
                .flag_o(invalid_flags[g])
            );
            lses_lane_counter #(.CNT_W(8)) unx_cnt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .clear_i(cnt_clear[g/LANES]),
                .err_i(unexpected_control_err_i[g]),
                .threshold_i(error_count_threshold),
                .flag_o(unexp_flags[g])
            );
        end
    endgenerate

    // page select of flag groups
    assign page_invalid = invalid_flags[link_page*LANES +: LANES];
    assign page_unexp = unexp_flags[link_page*LANES +: LANES];

    always @* begin
        next_dat = 32'h00000000;
        next_err = 1'b0;
        if (idx == `LSES_IDX_INVALID_FLAGS) begin
            next_dat = {24'h000000, page_invalid};
        end else if (idx == `LSES_IDX_UNEXP_FLAGS) begin
            next_dat = {24'h000000, page_unexp};
        end else if (idx == `LSES_IDX_LINK_PAGE) begin
            next_dat = {31'h00000000, link_page};
        end else if (idx == `LSES_IDX_THRESHOLD) begin
            next_dat = {24'h000000, error_count_threshold};
        end else if (idx == `LSES_IDX_CNT_CLEAR) begin
            next_dat = 32'h00000000;
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h00000000;
            link_page <= `LSES_LINK_PAGE_RESET;
            error_count_threshold <= `LSES_THRESHOLD_RESET;
            cnt_clear <= {LINKS{1'b0}};
        end else begin
            ack_o <= req && !next_err;
            err_o <= req && next_err;
            cnt_clear <= {LINKS{1'b0}};
            if (req) begin
                dat_o <= we_i ? 32'h00000000 : next_dat;
            end
            // flag registers ignore writes
            if (req && we_i && sel_i[0]) begin
                if (idx == `LSES_IDX_LINK_PAGE) begin
                    link_page <= dat_i[`LSES_LINK_PAGE_BIT];
                end else if (idx == `LSES_IDX_THRESHOLD) begin
                    error_count_threshold <= dat_i[7:0];
                end else if (idx == `LSES_IDX_CNT_CLEAR) begin
                    cnt_clear <= dat_i[LINKS-1:0];
                end
            end
        end
    end
endmodule

// ---- tb/lses_tx.sv ----
`timescale 1ns/1ns
module lses_tx (
    input wire clk_i,
    input wire [31:0] m_i,
    output reg [31:0] e_o
);
    always @(posedge clk_i) e_o <= m_i;
endmodule

// ---- tb/lses_chk_sva.sv ----
`timescale 1ns/1ns
module lses_chk (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [13:0] adr_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire err_o
);
    wire take;
    assign take = cyc_i && stb_i && !ack_o && !err_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    one_answer_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
        else $error("no answer");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
    err_pulse_a: assert property (err_o |=> !err_o) else $error("err held");
    flags_mapped_a: assert property (take && adr_i[13:3] == 11'h237 |=> ack_o && !err_o)
        else $error("flag register not answered");
    byte_wide_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    reset_clean_a: assert property ($fell(rst_i) |-> !dat_o && !ack_o && !err_o)
        else $error("outputs not clear after reset");
    flag_write_a: assert property (take && we_i && adr_i[13:3] == 11'h237
        |=> ack_o && !dat_o) else $error("flag write answer wrong");
    cover property (ack_o);
    cover property (err_o);
    cover property (cyc_i && stb_i);
    cover property (ack_o && dat_o[7:0] != 8'h00);
endmodule
bind lses_lane_symbol_error_status lses_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o));

// ---- tb/lses_lane_symbol_error_status_tb.sv ----
`timescale 1ns/1ns
module lses_lane_symbol_error_status_tb;
    reg clk_i = 0, rst_i = 1, c = 0, w = 0, e;
    reg [31:0] a = 0, d = 0, m = 0, r = 86, x = 0, rdata = 0;
    wire [31:0] o, v;
    wire k, g;
    integer n[0:31], miscompares = 0, checks = 0, i, p, t = 3;
    always #20 clk_i = ~clk_i;
    lses_tx i_lses_tx (.clk_i(clk_i), .m_i(m), .e_o(v));
    lses_lane_symbol_error_status i_lses_lane_symbol_error_status (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(c), .stb_i(c), .we_i(w), .adr_i(a[13:0]), .sel_i(4'hF), .dat_i(d), .dat_o(o),
        .ack_o(k), .err_o(g), .invalid_symbol_err_i(v[15:0]), .unexpected_control_err_i(v[31:16]));
    task finish_test;
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task ck(input [31:0] y, input [31:0] z);
        checks = checks + 1;
        if (y !== z) $display("MISMATCH %0t %h %h", $time, y, z);
        if (y !== z) miscompares = miscompares + 1;
    endtask
    function [31:0] xs(input [31:0] y);
        xs = y ^ y << 13;
        xs = xs ^ xs >> 17;
        xs = xs ^ xs << 5;
    endfunction
    task bus(input [11:0] b, input u, input [7:0] s);
        {c, w, a[13:0], d} <= {1'b1, u, b, 2'h0, 24'h0, s};
        @(posedge clk_i);
        repeat (20) if (!(k | g)) @(posedge clk_i);
        e = g;
        rdata = o;
        c <= 0;
        ck(k | g, 1);
        if (!(k | g)) finish_test;
        @(posedge clk_i);
    endtask
    initial begin
        for (i = 0; i < 32; i = i + 1) n[i] = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        bus(12'h46F, 0, 8'h00);
        ck(rdata, 0);
        repeat (6) begin
            r = xs(r);
            m <= r;
            @(posedge clk_i);
            for (i = 0; i < 32; i = i + 1) n[i] = n[i] + r[i];
        end
        m <= 0;
        bus(12'h301, 1, t[7:0]);
        bus(12'h46E, 1, 8'hFF);
        for (p = 0; p < 4; p = p + 1) begin
            bus(12'h300, 1, {7'h0, p[1]});
            for (i = 0; i < 8; i = i + 1) x[i] = n[{p[0], p[1], i[2:0]}] >= t;
            bus({11'h237, p[0]}, 0, 8'h00);
            ck(rdata, x);
        end
        bus(12'h300, 1, 8'h00);
        bus(12'h302, 1, 8'h01);
        for (i = 0; i < 32; i = i + 1) if (i[3] == 0) n[i] = 0;
        for (i = 0; i < 8; i = i + 1) x[i] = n[i] >= t;
        bus(12'h46E, 0, 8'h00);
        ck(rdata, x);
        bus(12'h300, 1, 8'h01);
        for (i = 0; i < 8; i = i + 1) x[i] = n[i + 8] >= t;
        bus(12'h46E, 0, 8'h00);
        ck(rdata, x);
        t = 0;
        bus(12'h301, 1, t[7:0]);
        bus(12'h301, 0, 8'h00);
        ck(rdata, t);
        for (i = 0; i < 8; i = i + 1) x[i] = n[i + 24] >= t;
        bus(12'h46F, 0, 8'h00);
        ck(rdata, x);
        bus(12'h5A5, 0, 8'h00);
        ck(e, 1);
        finish_test;
    end
endmodule
